// ### core/sgd_arbiter.sv
// sgd_arbiter: picks which of two channels the sequencer serves next
// assumes take pulses once per granted descriptor
`timescale 1ns/100ps
module sgd_arbiter
	import sgd_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [1:0] req,
	input  wire logic [1:0] prio,
	input  wire logic       take,
	output      logic       gnt_valid,
	output      logic       gnt_ch
);
	logic last_ch;
	wire  both = req[0] & req[1];
	wire  rot  = (prio != SGD_PRIO_CH0) && (prio != SGD_PRIO_CH1);
	assign gnt_ch    = both ? (rot ? ~last_ch : (prio == SGD_PRIO_CH1))
		: req[1];
	assign gnt_valid = |req;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			last_ch <= 1'b1;
		else if (take)
			last_ch <= gnt_ch;
	end

	property p_fixed0;
		@(posedge pclk) disable iff (!presetn)
		(both && prio == SGD_PRIO_CH0) |-> !gnt_ch;
	endproperty
	a_fixed0: assert property (p_fixed0) else $error("ch0 priority lost");
	property p_rotate;
		@(posedge pclk) disable iff (!presetn)
		(take && both && rot) ##1 (both && rot) |-> gnt_ch != $past(gnt_ch);
	endproperty
	a_rotate: assert property (p_rotate) else $error("no rotation");
endmodule // sgd_arbiter

// ### core/sgd_dma_ctrl.sv
// sgd_dma_ctrl: two-channel scatter/gather dma control with apb registers
// assumes a memory port for descriptors and an outside data mover
`timescale 1ns/100ps
module sgd_dma_ctrl
	import sgd_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	output      logic        mem_req,
	output      logic        mem_write,
	output      logic        mem_on_pci,
	output      logic [31:0] mem_addr,
	output      logic [31:0] mem_wdata,
	input  wire logic        mem_ack,
	input  wire logic [31:0] mem_rdata,
	output      logic        xfer_req,
	output      logic        xfer_ch,
	output      logic        xfer_to_local,
	output      logic        xfer_dac,
	output      logic [31:0] xfer_pci_addr,
	output      logic [31:0] xfer_pci_upper,
	output      logic [31:0] xfer_local_addr,
	output      logic [30:0] xfer_count,
	output      logic        xfer_abort,
	input  wire logic        xfer_done,
	input  wire logic [5:0]  buf_words,
	input  wire logic [5:0]  line_offset,
	input  wire logic        word_written,
	input  wire logic        tgt_disconnect,
	input  wire logic        tail_partial,
	input  wire logic        end_of_transfer_n,
	input  wire logic        demand_request0_n,
	input  wire logic        demand_request1_n,
	output      logic        pci_go,
	output      logic        use_mwi,
	output      logic        pci_int,
	output      logic        local_int
);
	////////////////////////////////////////////////////////////////////
	sgd_state_t  state;
	logic        cur;
	logic [2:0]  widx;
	logic [31:0] desc_base;
	logic [31:0] dw [5];
	logic [31:0] mode [2];
	logic [31:0] dpr [2];
	logic [31:0] upper [2];
	logic [31:0] arb_reg;
	logic [7:0]  cls_reg;
	logic [31:0] cmd_reg;
	logic [1:0]  en;
	logic [1:0]  run;
	logic [1:0]  done;
	logic [1:0]  ip;
	logic [1:0]  abortp;
	logic        gnt_valid;
	logic        gnt_ch;

	////////////////////////////////////////////////////////////////////
	// apb decode
	wire        acc      = psel & penable & pready;
	wire        wr       = acc & pwrite;
	wire        setup_rd = psel & ~penable & ~pwrite;
	wire        in_ch    = paddr < SGD_OFF_ARB;
	wire        ch_a     = paddr[SGD_CH_BIT];
	wire [11:0] reg_off  = paddr & SGD_CH_MASK;
	wire hit_mode  = in_ch & (reg_off == SGD_OFF_MODE);
	wire hit_csr   = in_ch & (reg_off == SGD_OFF_CSR);
	wire hit_dpr   = in_ch & (reg_off == SGD_OFF_DPR);
	wire hit_upper = in_ch & (reg_off == SGD_OFF_UPPER);
	wire hit_arb   = paddr == SGD_OFF_ARB;
	wire hit_cls   = paddr == SGD_OFF_CLS;
	wire hit_cmd   = paddr == SGD_OFF_CMD;
	wire hit_int   = paddr == SGD_OFF_INTERRUPT_CONTROL_STATUS;
	wire mapped    = hit_mode | hit_csr | hit_dpr | hit_upper | hit_arb
		| hit_cls | hit_cmd | hit_int;
	wire wr_csr    = wr & hit_csr;

	function automatic logic [31:0] csr_word(input logic c);
		csr_word = 32'h0000_0000;
		csr_word[SGD_CSR_EN]    = en[c];
		csr_word[SGD_CSR_ABORT] = abortp[c];
		csr_word[SGD_CSR_DONE]  = done[c];
	endfunction

	wire [31:0] int_word = {9'h000, ip, 21'h000000};
	wire [31:0] rd_mux =
		hit_mode  ? mode[ch_a] :
		hit_csr   ? csr_word(ch_a) :
		hit_dpr   ? dpr[ch_a] :
		hit_upper ? upper[ch_a] :
		hit_arb   ? arb_reg :
		hit_cls   ? {24'h000000, cls_reg} :
		hit_cmd   ? cmd_reg :
		hit_int   ? int_word : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////
	// sequencer decode
	wire [31:0] size_w  = dw[SGD_W_SIZE];
	wire [31:0] next_w  = dw[SGD_W_NEXT];
	wire        eoc     = next_w[SGD_DP_EOC];
	wire        dacld   = mode[cur][SGD_MODE_DACLD];
	wire [2:0]  last_ix = dacld ? SGD_W_UPPER : SGD_W_NEXT;
	wire [30:0] cnt     = size_w[30:0];
	// flag only counts in valid mode
	wire vbit_ok = ~mode[cur][SGD_MODE_VALID] | size_w[SGD_CNT_VALID];
	wire ev      = state == S_EVAL;
	wire ev_hold = ev & ~vbit_ok;
	wire ev_stop = ev_hold & mode[cur][SGD_MODE_VSTOP];
	wire nx      = state == S_NEXT;
	wire take    = (state == S_IDLE) & gnt_valid;
	// pending abort ends the next start
	wire fin_idle = take & abortp[gnt_ch];
	wire fin_nx   = nx & (eoc | abortp[cur]);
	wire fin      = fin_idle | fin_nx;
	wire fin_ch   = fin_idle ? gnt_ch : cur;
	wire [31:0] next_upper = dacld ? dw[SGD_W_UPPER] : upper[cur];
	wire [1:0] dreq_n = {demand_request1_n, demand_request0_n};
	wire [1:0] intsel = {mode[1][SGD_MODE_INTSEL], mode[0][SGD_MODE_INTSEL]};
	wire [1:0] cur_mask = cur ? 2'h2 : 2'h1;
	// eot or demand drop flushes buffered words
	wire flush = ~end_of_transfer_n
		| (mode[cur][SGD_MODE_DEMAND] & dreq_n[cur]);

	logic [1:0] ip_set;
	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			ip_set[c] = (fin && fin_ch == c && mode[c][SGD_MODE_DONEIE])
				|| (nx && cur == c && next_w[SGD_DP_TCINT]);
		end
	end

	////////////////////////////////////////////////////////////////////
	sgd_arbiter u_arb (
		.pclk      (pclk),
		.presetn   (presetn),
		.req       (run),
		.prio      (arb_reg[SGD_ARB_PRIO +: 2]),
		.take      (take),
		.gnt_valid (gnt_valid),
		.gnt_ch    (gnt_ch)
	);

	sgd_mwi u_mwi (
		.pclk           (pclk),
		.presetn        (presetn),
		.mode_en        (mode[cur][SGD_MODE_MWI]),
		.cmd_en         (cmd_reg[SGD_CMD_MWI]),
		.line_size      (cls_reg),
		.buf_words      (buf_words),
		.line_offset    (line_offset),
		.word_written   (word_written),
		.tgt_disconnect (tgt_disconnect),
		.flush          (flush),
		.tail_partial   (tail_partial),
		.pci_go         (pci_go),
		.use_mwi        (use_mwi)
	);

	////////////////////////////////////////////////////////////////////
	// apb answer: zero wait, read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= 1'b1;
			prdata  <= setup_rd ? rd_mux : 32'h0000_0000;
			pslverr <= psel & ~penable & ~mapped;
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers, channel flags, interrupt lines
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int c = 0; c < 2; c++)
			begin
				mode[c]  <= 32'h0000_0000;
				dpr[c]   <= 32'h0000_0000;
				upper[c] <= 32'h0000_0000;
			end
			arb_reg   <= 32'h0000_0000;
			cls_reg   <= 8'h00;
			cmd_reg   <= 32'h0000_0000;
			en        <= 2'h0;
			run       <= 2'h0;
			done      <= 2'h0;
			ip        <= 2'h0;
			abortp    <= 2'h0;
			pci_int   <= 1'b0;
			local_int <= 1'b0;
		end
		else
		begin
			if (wr && hit_arb)
				arb_reg <= pwdata;
			if (wr && hit_cls)
				cls_reg <= pwdata[7:0];
			if (wr && hit_cmd)
				cmd_reg <= pwdata;
			for (int c = 0; c < 2; c++)
			begin
				if (wr && hit_mode && ch_a == c)
					mode[c] <= pwdata;
				if (nx && cur == c)
					dpr[c] <= next_w;
				else if (wr && hit_dpr && ch_a == c)
					dpr[c] <= pwdata;
				if (ev && vbit_ok && dacld && cur == c)
					upper[c] <= dw[SGD_W_UPPER];
				else if (wr && hit_upper && ch_a == c)
					upper[c] <= pwdata;
				if (wr_csr && ch_a == c)
					en[c] <= pwdata[SGD_CSR_EN];
				// start bit with enable set in the same write restarts a paused channel
				if (wr_csr && ch_a == c && pwdata[SGD_CSR_START]
					&& pwdata[SGD_CSR_EN])
					run[c] <= 1'b1;
				else if ((fin && fin_ch == c) || (ev_stop && cur == c))
					run[c] <= 1'b0;
				// done marks the end of a chain or an abort
				if (fin && fin_ch == c)
					done[c] <= 1'b1;
				else if (wr_csr && ch_a == c && pwdata[SGD_CSR_START])
					done[c] <= 1'b0;
				if (wr_csr && ch_a == c && pwdata[SGD_CSR_ABORT])
					abortp[c] <= 1'b1;
				else if (fin && fin_ch == c && abortp[c])
					abortp[c] <= 1'b0;
				// clear write, a new event wins
				if (ip_set[c])
					ip[c] <= 1'b1;
				else if (wr_csr && ch_a == c && pwdata[SGD_CSR_CLRINT])
					ip[c] <= 1'b0;
			end
			pci_int   <= |(ip & intsel);
			local_int <= |(ip & ~intsel);
		end
	end

	////////////////////////////////////////////////////////////////////
	// descriptor sequencer, one descriptor per grant
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state           <= S_IDLE;
			cur             <= 1'b0;
			widx            <= 3'h0;
			desc_base       <= 32'h0000_0000;
			for (int i = 0; i < 5; i++)
				dw[i] <= 32'h0000_0000;
			mem_req         <= 1'b0;
			mem_write       <= 1'b0;
			mem_on_pci      <= 1'b0;
			mem_addr        <= 32'h0000_0000;
			mem_wdata       <= 32'h0000_0000;
			xfer_req        <= 1'b0;
			xfer_ch         <= 1'b0;
			xfer_to_local   <= 1'b0;
			xfer_dac        <= 1'b0;
			xfer_pci_addr   <= 32'h0000_0000;
			xfer_pci_upper  <= 32'h0000_0000;
			xfer_local_addr <= 32'h0000_0000;
			xfer_count      <= 31'h0000_0000;
			xfer_abort      <= 1'b0;
		end
		else
		begin
			unique case (state)
			S_IDLE:
			begin
				widx <= 3'h0;
				if (take && !abortp[gnt_ch])
				begin
					cur        <= gnt_ch;
					desc_base  <= {dpr[gnt_ch][31:4], 4'h0};
					mem_on_pci <= dpr[gnt_ch][SGD_DP_LOC];
					state      <= S_LOAD;
				end
			end
			S_LOAD:
			begin
				if (mem_req && mem_ack)
				begin
					mem_req  <= 1'b0;
					dw[widx] <= mem_rdata;
					widx     <= widx + 3'h1;
					if (widx == last_ix)
						state <= S_EVAL;
				end
				else if (!mem_req)
				begin
					// 32-bit address only on this port
					mem_req   <= 1'b1;
					mem_write <= 1'b0;
					mem_addr  <= desc_base + {27'h0000000, widx, 2'h0};
				end
			end
			S_EVAL:
			begin
				// back to idle, same pointer is re-read
				if (!vbit_ok)
					state <= S_IDLE;
				// zero count steps to the next descriptor
				else if (cnt == 31'h0000_0000)
					state <= S_NEXT;
				else
				begin
					xfer_req        <= 1'b1;
					xfer_ch         <= cur;
					xfer_to_local   <= next_w[SGD_DP_DIR];
					// dac for data when upper is nonzero
					xfer_dac        <= next_upper != 32'h0000_0000;
					xfer_pci_upper  <= next_upper;
					xfer_pci_addr   <= dw[SGD_W_PCI];
					xfer_local_addr <= dw[SGD_W_LOC];
					xfer_count      <= cnt;
					state           <= S_XFER;
				end
			end
			S_XFER:
			begin
				// mover may finish a word or two
				xfer_abort <= abortp[cur];
				if (xfer_done)
				begin
					xfer_req   <= 1'b0;
					xfer_abort <= 1'b0;
					state      <= mode[cur][SGD_MODE_CLRCNT] ? S_WBACK
						: S_NEXT;
				end
			end
			S_WBACK:
			begin
				if (mem_req && mem_ack)
				begin
					mem_req <= 1'b0;
					state   <= S_NEXT;
				end
				else if (!mem_req)
				begin
					// zero size word, valid goes too
					mem_req   <= 1'b1;
					mem_write <= 1'b1;
					mem_addr  <= desc_base + SGD_SIZE_BYTE;
					mem_wdata <= 32'h0000_0000;
				end
			end
			S_NEXT:
				state <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_dac;
		xfer_req |-> xfer_dac == (xfer_pci_upper != 32'h0000_0000);
	endproperty
	a_dac: assert property (p_dac) else $error("dac mismatch");
	property p_chain;
		(ev && vbit_ok && dacld && cnt != 31'h0000_0000)
		|=> xfer_pci_upper == $past(dw[SGD_W_UPPER]);
	endproperty
	a_chain: assert property (p_chain) else $error("upper not loaded");
	property p_wback;
		(state == S_WBACK && mem_req) |-> mem_write
		&& mem_wdata == 32'h0000_0000 && mem_addr == desc_base + SGD_SIZE_BYTE;
	endproperty
	a_wback: assert property (p_wback) else $error("bad write-back");
	property p_ignore;
		(ev && !mode[cur][SGD_MODE_VALID] && cnt != 31'h0000_0000)
		|=> state == S_XFER ##1 xfer_req;
	endproperty
	a_ignore: assert property (p_ignore) else $error("valid not ignored");
	property p_skip;
		(ev && vbit_ok && cnt == 31'h0000_0000 && !eoc)
		|=> nx && !xfer_req ##1 state == S_IDLE;
	endproperty
	a_skip: assert property (p_skip) else $error("zero count not skipped");
	property p_poll;
		(ev_hold && !ev_stop) |=> state == S_IDLE && (run & cur_mask) != 2'h0;
	endproperty
	a_poll: assert property (p_poll) else $error("poll stopped");
	property p_stop;
		ev_stop |=> (run & $past(cur_mask)) == 2'h0 && state == S_IDLE;
	endproperty
	a_stop: assert property (p_stop) else $error("did not pause");
	property p_clr;
		(wr_csr && !ch_a && pwdata[SGD_CSR_CLRINT] && !ip_set[0]) |=> !ip[0];
	endproperty
	a_clr: assert property (p_clr) else $error("interrupt not cleared");
	property p_route;
		ip == 2'h1 |=> pci_int == $past(intsel[0])
		&& local_int != pci_int;
	endproperty
	a_route: assert property (p_route) else $error("bad routing");
	property p_icsr;
		(setup_rd && hit_int) |=> prdata[SGD_INT_CH1:SGD_INT_CH0] == $past(ip);
	endproperty
	a_icsr: assert property (p_icsr) else $error("pending bits wrong");

	c_skip:  cover property (ev && vbit_ok && cnt == 31'h0000_0000 && !eoc);
	c_chain: cover property (fin_nx && eoc);
	c_abort: cover property (fin_idle);
	c_stop:  cover property (ev_stop);
endmodule // sgd_dma_ctrl

// ### core/sgd_mwi.sv
// sgd_mwi: decides between invalidate and plain writes toward pci
// assumes buf_words counts words read from the local bus not yet written
`timescale 1ns/100ps
module sgd_mwi
	import sgd_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       mode_en,
	input  wire logic       cmd_en,
	input  wire logic [7:0] line_size,
	input  wire logic [5:0] buf_words,
	input  wire logic [5:0] line_offset,
	input  wire logic       word_written,
	input  wire logic       tgt_disconnect,
	input  wire logic       flush,
	input  wire logic       tail_partial,
	output      logic       pci_go,
	output      logic       use_mwi
);
	logic [5:0] fix_left;
	// only 8 or 16 word lines
	wire size_ok = (line_size == SGD_LINE_8) || (line_size == SGD_LINE_16);
	wire line_ok = mode_en & cmd_en & size_ok;
	wire [5:0] line_w = line_size[5:0];
	wire full   = buf_words >= line_w;
	wire fixing = fix_left != 6'h00;
	// flush and tail go out as plain writes
	wire next_use = line_ok & full & ~fixing & ~flush & ~tail_partial
		& ~tgt_disconnect;
	// with mwi usable (enables set, 8 or 16 word line), hold pci off until a whole line is buffered
	// keeps bursting while another line is full, or on flush, tail or line fix-up
	wire next_go = ~line_ok | full | flush | tail_partial | fixing;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fix_left <= 6'h00;
			pci_go   <= 1'b0;
			use_mwi  <= 1'b0;
		end
		else
		begin
			// finish a broken line with plain writes
			if (tgt_disconnect && use_mwi)
				fix_left <= line_w - line_offset;
			else if (word_written && fixing)
				fix_left <= fix_left - 6'h01;
			pci_go  <= next_go;
			use_mwi <= next_use;
		end
	end

	property p_size;
		@(posedge pclk) disable iff (!presetn)
		use_mwi |-> $past(size_ok && mode_en && cmd_en);
	endproperty
	a_size: assert property (p_size) else $error("mwi not allowed");
	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		(line_ok && !full && !flush && !tail_partial && !fixing) |=> !pci_go;
	endproperty
	a_hold: assert property (p_hold) else $error("pci before full line");
	property p_disc;
		@(posedge pclk) disable iff (!presetn)
		(tgt_disconnect && use_mwi) |=> !use_mwi;
	endproperty
	a_disc: assert property (p_disc) else $error("mwi after disconnect");
endmodule // sgd_mwi

// ### core/sgd_pkg.sv
// sgd_pkg: register map, field positions and states of the s/g dma control
// assumes a 32-bit apb register bus clocked by pclk
package sgd_pkg;
	// register byte offsets, channel block repeats every stride
	localparam logic [11:0] SGD_OFF_MODE   = 12'h000;
	localparam logic [11:0] SGD_OFF_CSR    = 12'h004;
	localparam logic [11:0] SGD_OFF_DPR    = 12'h008;
	localparam logic [11:0] SGD_OFF_UPPER  = 12'h00c;
	localparam logic [11:0] SGD_OFF_ARB    = 12'h020;
	localparam logic [11:0] SGD_OFF_CLS    = 12'h024;
	localparam logic [11:0] SGD_OFF_CMD    = 12'h028;
	localparam logic [11:0] SGD_OFF_INTERRUPT_CONTROL_STATUS = 12'h02c;
	localparam logic [11:0] SGD_CH_MASK    = 12'h00f;
	localparam int          SGD_CH_BIT     = 4;
	// mode register fields
	localparam int SGD_MODE_DEMAND = 12;
	localparam int SGD_MODE_DONEIE = 10;
	localparam int SGD_MODE_MWI    = 13;
	localparam int SGD_MODE_CLRCNT = 16;
	localparam int SGD_MODE_INTSEL = 17;
	localparam int SGD_MODE_DACLD  = 18;
	localparam int SGD_MODE_VALID  = 20;
	localparam int SGD_MODE_VSTOP  = 21;
	// control/status fields
	localparam int SGD_CSR_EN     = 0;
	localparam int SGD_CSR_START  = 1;
	localparam int SGD_CSR_ABORT  = 2;
	localparam int SGD_CSR_CLRINT = 3;
	localparam int SGD_CSR_DONE   = 4;
	// descriptor pointer and count fields, arbiter, command and interrupt bits
	localparam int SGD_DP_LOC    = 0;
	localparam int SGD_DP_EOC    = 1;
	localparam int SGD_DP_TCINT  = 2;
	localparam int SGD_DP_DIR    = 3;
	localparam int SGD_CNT_VALID = 31;
	localparam int SGD_ARB_PRIO  = 19;
	localparam int SGD_CMD_MWI   = 4;
	localparam int SGD_INT_CH0   = 21;
	localparam int SGD_INT_CH1   = 22;
	localparam logic [1:0] SGD_PRIO_ROT = 2'h0;
	localparam logic [1:0] SGD_PRIO_CH0 = 2'h1;
	localparam logic [1:0] SGD_PRIO_CH1 = 2'h2;
	// descriptor word indices, size word byte offset and line sizes
	localparam logic [2:0] SGD_W_PCI   = 3'h0;
	localparam logic [2:0] SGD_W_LOC   = 3'h1;
	localparam logic [2:0] SGD_W_SIZE  = 3'h2;
	localparam logic [2:0] SGD_W_NEXT  = 3'h3;
	localparam logic [2:0] SGD_W_UPPER = 3'h4;
	localparam logic [31:0] SGD_SIZE_BYTE = 32'h0000_0008;
	localparam logic [7:0] SGD_LINE_8  = 8'h08;
	localparam logic [7:0] SGD_LINE_16 = 8'h10;
	typedef enum logic [2:0] {
		S_IDLE, S_LOAD, S_EVAL, S_XFER, S_WBACK, S_NEXT
	} sgd_state_t;
endpackage

// ### tb/sgd_far_model.sv
// sgd_far_model: descriptor memory and data mover facing the dma control
// assumes requests are held until answered, one answer per request
`timescale 1ns/100ps
module sgd_far_model
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        mem_req,
	input  wire logic        mem_write,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	input  wire logic        xfer_req,
	output      logic        mem_ack,
	output      logic [31:0] mem_rdata,
	output      logic        xfer_done,
	output      logic [7:0]  xfer_seen
);
	logic [31:0] mem [0:31];
	logic [1:0]  wt;
	logic        slow;
	// answers alternate prompt and slow; idle read data never holds still
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mem_ack   <= 1'b0;
			xfer_done <= 1'b0;
			xfer_seen <= 8'h00;
			mem_rdata <= 32'h0000_0000;
			wt        <= 2'h0;
			slow      <= 1'b0;
		end
		else
		begin
			mem_ack   <= 1'b0;
			xfer_done <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if ((mem_req && !mem_ack) || (xfer_req && !xfer_done))
			begin
				if (wt != 2'h0)
					wt <= wt - 2'h1;
				else
				begin
					wt   <= slow ? 2'h3 : 2'h0;
					slow <= !slow;
					if (mem_req)
					begin
						mem_ack   <= 1'b1;
						mem_rdata <= mem[mem_addr[6:2]];
						if (mem_write)
							mem[mem_addr[6:2]] <= mem_wdata;
					end
					else
					begin
						xfer_done <= 1'b1;
						xfer_seen <= xfer_seen + 8'h01;
					end
				end
			end
		end
	end
endmodule // sgd_far_model

// ### tb/tb_sgd_dma_ctrl.sv
// tb_sgd_dma_ctrl: apb-driven bench, expectations queued and popped
// assumes the far model answers memory and transfer requests
`timescale 1ns/100ps
module tb_sgd_dma_ctrl;
	import sgd_pkg::*;
	typedef struct { logic [31:0] v; logic [31:0] m; } sgd_note_t;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, pa;
	logic [5:0]  buf_words = 0, line_offset = 0;
	logic        tail_partial = 0, xreq_d = 0, word_wr = 0, tgt_disc = 0;
	logic        eot_n = 1;
	logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, xfer_pci_addr;
	logic [31:0] xfer_pci_upper, xfer_local_addr;
	logic        pready, pslverr, mem_req, mem_write, mem_on_pci, mem_ack;
	logic        xfer_req, xfer_ch, xfer_to_local, xfer_dac, xfer_abort;
	logic        xfer_done, pci_go, use_mwi, pci_int, local_int;
	logic [30:0] xfer_count;
	logic [7:0]  xfer_seen;
	logic [15:0] rnd = 16'h4b10;
	sgd_note_t   nq[$];
	int          err_count = 0, cmp_count = 0, i;
	always #4 pclk = ~pclk;
	sgd_dma_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_write,
		.mem_on_pci, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .xfer_req,
		.xfer_ch, .xfer_to_local, .xfer_dac, .xfer_pci_addr, .xfer_pci_upper,
		.xfer_local_addr, .xfer_count, .xfer_abort, .xfer_done, .buf_words,
		.line_offset, .word_written(word_wr), .tgt_disconnect(tgt_disc),
		.tail_partial, .end_of_transfer_n(eot_n), .demand_request0_n(1'b1),
		.demand_request1_n(1'b1), .pci_go, .use_mwi, .pci_int, .local_int);
	sgd_far_model far (.pclk, .presetn, .mem_req, .mem_write, .mem_addr,
		.mem_wdata, .xfer_req, .mem_ack, .mem_rdata, .xfer_done, .xfer_seen);
	////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic pop(string nm, logic [31:0] s);
		sgd_note_t n;
		n = nq.size() ? nq.pop_front() : '{32'hx, 32'hffff_ffff};
		chk(nm, s & n.m, n.v & n.m);
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(logic [11:0] a, logic [31:0] e, logic [31:0] m);
		nq.push_back('{e, m});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic note(logic [31:0] v);
		nq.push_back('{v, 32'hffff_ffff});
	endtask
	task automatic settle(logic [11:0] a, logic [31:0] d);
		apb(1'b1, a, d);
		repeat (3) @(posedge pclk);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// watcher: read data at the access edge, transfer fields at request
	always @(posedge pclk)
	begin
		xreq_d <= xfer_req;
		if (psel && penable && pready && !pwrite)
		begin
			pop("prdata", prdata);
			chk("pslverr", {31'h0, pslverr}, {31'h0, paddr > SGD_OFF_INTERRUPT_CONTROL_STATUS});
		end
		if (xfer_req && !xreq_d)
		begin
			pop("xfer_pci_addr", xfer_pci_addr);
			pop("xfer_dac_count", {xfer_dac, xfer_count});
			pop("xfer_local_addr", xfer_local_addr);
			pop("xfer_pci_upper", xfer_pci_upper);
			pop("xfer_side", {28'h0, xfer_ch, xfer_to_local, mem_on_pci,
				xfer_abort});
		end
	end
	initial
	begin
		#160000;
		err_count++;
		complete_run;
	end
	initial
	begin
		rnd = lfsr(rnd);
		pa = {rnd, 16'h0};
		for (i = 0; i < 32; i++) far.mem[i] = 32'h0;
		// valid zero-count head at 0x40, real descriptor at 0x50
		far.mem[18] = 32'h8000_0000;
		far.mem[19] = 32'h0000_0051;
		far.mem[20] = pa;
		far.mem[21] = 32'h0000_8000;
		far.mem[22] = 32'h8000_0010;
		far.mem[23] = 32'h0000_0006;
		// ch1 five-word descriptor at 0x60, valid flag left clear
		far.mem[24] = ~pa;
		far.mem[25] = 32'h0000_9000;
		far.mem[26] = 32'h0000_0020;
		far.mem[27] = 32'h0000_0002;
		far.mem[28] = 32'h0000_0005;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h030, 32'h0, 32'hffff_ffff);
		rd(SGD_OFF_INTERRUPT_CONTROL_STATUS, 32'h0, 32'hffff_ffff);
		apb(1'b1, SGD_OFF_UPPER, 32'h1);
		apb(1'b1, SGD_OFF_DPR, 32'h41);
		apb(1'b1, SGD_OFF_MODE, 32'h0013_0400 | (32'h1 << SGD_MODE_VALID));
		note(pa);
		note(32'h8000_0010);
		note(32'h0000_8000);
		note(32'h0000_0001);
		note(32'h0000_0002);
		apb(1'b1, SGD_OFF_CSR, 32'h3);
		for (i = 0; i < 300 && pci_int !== 1'b1; i++) @(posedge pclk);
		chk("pci_int", {31'h0, pci_int}, 32'h1);
		chk("local_int", {31'h0, local_int}, 32'h0);
		chk("size_word", far.mem[22], 32'h0);
		rd(SGD_OFF_INTERRUPT_CONTROL_STATUS, 32'h0020_0000, 32'h0060_0000);
		rd(SGD_OFF_CSR, 32'h10, 32'h10);
		settle(SGD_OFF_CSR, 32'h8);
		chk("pci_int", {31'h0, pci_int}, 32'h0);
		rd(SGD_OFF_INTERRUPT_CONTROL_STATUS, 32'h0, 32'h0060_0000);
		// enable off first, then abort, then start
		apb(1'b1, SGD_OFF_CSR, 32'h0);
		apb(1'b1, SGD_OFF_CSR, 32'h4);
		rd(SGD_OFF_CSR, 32'h4, 32'h5);
		apb(1'b1, SGD_OFF_CSR, 32'h3);
		repeat (40) @(posedge pclk);
		chk("xfers", {24'h0, xfer_seen}, 32'h1);
		rd(SGD_OFF_CSR, 32'h10, 32'h10);
		apb(1'b1, SGD_OFF_CMD, 32'h10);
		apb(1'b1, SGD_OFF_CLS, 32'h8);
		buf_words <= 6'h07;
		settle(SGD_OFF_MODE, 32'h1 << SGD_MODE_MWI);
		chk("pci_go", {31'h0, pci_go}, 32'h0);
		buf_words <= 6'h08;
		repeat (3) @(posedge pclk);
		chk("pci_go", {31'h0, pci_go}, 32'h1);
		chk("use_mwi", {31'h0, use_mwi}, 32'h1);
		// disconnect six words into the line leaves two plain writes
		line_offset <= 6'h06;
		tgt_disc <= 1'b1;
		@(posedge pclk);
		tgt_disc <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("use_mwi", {31'h0, use_mwi}, 32'h0);
		word_wr <= 1'b1;
		repeat (2) @(posedge pclk);
		word_wr <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("use_mwi", {31'h0, use_mwi}, 32'h1);
		buf_words <= 6'h07;
		eot_n <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("pci_go", {31'h0, pci_go}, 32'h1);
		chk("use_mwi", {31'h0, use_mwi}, 32'h0);
		buf_words <= 6'h08;
		eot_n <= 1'b1;
		tail_partial <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("use_mwi", {31'h0, use_mwi}, 32'h0);
		tail_partial <= 1'b0;
		// buffer always holds a full line, so only size and enables rule
		buf_words <= 6'h3f;
		rnd = lfsr(rnd);
		settle(SGD_OFF_CLS, {24'h0, rnd[7:0] | 8'h01});
		chk("use_mwi", {31'h0, use_mwi}, 32'h0);
		settle(SGD_OFF_CLS, 32'h10);
		chk("use_mwi", {31'h0, use_mwi}, 32'h1);
		settle(SGD_OFF_CMD, 32'h0);
		chk("use_mwi", {31'h0, use_mwi}, 32'h0);
		// ch1 chain load: fifth word replaces a zero upper register
		apb(1'b1, 12'h018, 32'h61);
		apb(1'b1, 12'h010, 32'h1 << SGD_MODE_DACLD);
		note(~pa);
		note(32'h8000_0020);
		note(32'h0000_9000);
		note(32'h0000_0005);
		note(32'h0000_000a);
		apb(1'b1, 12'h014, 32'h3);
		for (i = 0; i < 300 && xfer_seen != 8'h02; i++) @(posedge pclk);
		repeat (4) @(posedge pclk);
		rd(12'h01c, 32'h5, 32'hffff_ffff);
		rd(12'h014, 32'h10, 32'h10);
		complete_run;
	end
endmodule // tb_sgd_dma_ctrl
